/* File: hdl/addr_step.sv */
// Advances a start location by one sector in either address form.
// Assumes the geometry limits are fixed by the drive.
`timescale 1ns/1ns
`default_nettype none
module addr_step #(
  parameter logic [7:0] sectors_per_track = 8'h3f,
  parameter logic [3:0] heads = 4'hf
) (
  input wire logic lba_mode,
  input wire logic [27:0] addr,
  output logic [27:0] next_addr
);
  // CHS layout: [27:24] head, [23:8] cylinder, [7:0] sector.
  always_comb begin
    next_addr = addr;
    if (lba_mode) begin
      next_addr = addr + 28'h0000001;
    end else if (addr[7:0] < sectors_per_track) begin
      next_addr[7:0] = addr[7:0] + 8'h01;
    end else begin
      next_addr[7:0] = 8'h01;
      if (addr[27:24] < heads) begin
        next_addr[27:24] = addr[27:24] + 4'h1;
      end else begin
        next_addr[27:24] = 4'h0;
        next_addr[23:8] = addr[23:8] + 16'h0001;
      end
    end
  end
endmodule : addr_step
`default_nettype wire

/* File: hdl/log_check.sv */
// Validity check for a log write command.
// Assumes the log directory limit and feature table are driven by drive firmware.
`timescale 1ns/1ns
`default_nettype none
module log_check
  import wrmul_pkg::*;
#(
  parameter int logs = 256
) (
  input wire logic [7:0] log_address,
  input wire logic [15:0] sector_count,
  input wire logic [15:0] first_sector,
  input wire logic [15:0] log_limit,
  input wire logic [logs-1:0] log_read_only,
  input wire logic [logs-1:0] log_supported,
  output logic abort
);
  logic [16:0] last_needed;
  always_comb begin
    last_needed = {1'b0, first_sector} + {1'b0, sector_count};
    abort = log_read_only[log_address] || !log_supported[log_address] ||
            (sector_count == 16'h0000) || (sector_count > log_limit) ||
            (last_needed > {1'b0, log_limit});
  end
endmodule : log_check
`default_nettype wire

/* File: hdl/write_cmd.sv */
// Device-side interpreter for the log DMA write and block-interrupt write commands.
// Assumes the host writes the command block before the command byte, and that media
// and DMA engines answer with single-cycle done and word strobes.
`timescale 1ns/1ns
`default_nettype none
module write_cmd
  import wrmul_pkg::*;
#(
  parameter int logs = 256,
  parameter logic [7:0] block_size = 8'h10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire task_file_t task_file,
  input wire logic command_write,
  input wire logic [7:0] command,
  input wire logic data_write,
  input wire logic [15:0] data_in,
  input wire data_word_t dma_word,
  input wire logic [15:0] log_limit,
  input wire logic [logs-1:0] log_read_only,
  input wire logic [logs-1:0] log_supported,
  input wire logic media_done,
  input wire logic media_error,
  output logic [7:0] error_flags,
  output logic [7:0] drive_status,
  output logic [7:0] drive_head_select,
  output logic [7:0] count_out,
  output logic [7:0] sector_out,
  output logic [7:0] cyl_low_out,
  output logic [7:0] cyl_high_out,
  output logic interrupt,
  output logic dma_request,
  output data_word_t media_word,
  output logic media_commit
);

  ////////////////////////////////////////////////////////////////////////////
  cmd_state_t state;
  logic log_abort;
  logic lba_mode;
  logic [27:0] addr;
  logic [27:0] next_addr;
  logic [27:0] start_addr;
  logic [15:0] remaining;
  logic [7:0] word_count;
  logic [7:0] block_left;
  logic word_in;
  logic sector_end;
  logic is_dma;
  logic last_word;
  logic cmd_refused;

  log_check #(.logs(logs)) u_check (
    .log_address(task_file.sector),
    .sector_count({task_file.count_prev, task_file.count}),
    .first_sector({task_file.cyl_low_prev, task_file.cyl_low}),
    .log_limit(log_limit),
    .log_read_only(log_read_only),
    .log_supported(log_supported),
    .abort(log_abort)
  );

  addr_step u_step (
    .lba_mode(lba_mode),
    .addr(addr),
    .next_addr(next_addr)
  );

  always_comb begin
    start_addr = {task_file.head_select[3:0], task_file.cyl_high, task_file.cyl_low,
                  task_file.sector};
  end

  // one word per access
  // A word is only taken while the matching request is shown, so a host that writes
  // early, in the cycle before the data request rises, cannot slip a word in.
  assign word_in = (state == st_pio_data && data_write && drive_status[st_data_req]) ||
                   (state == st_dma_data && dma_word.valid && dma_request);
  assign sector_end = word_in && (word_count == 8'(words_per_sector - 1));
  // The closing word of the command; the state, address hold, strobes and status flags all key off it.
  assign last_word = sector_end && (remaining == 16'h0001);
  assign cmd_refused = (command == op_log_dma && log_abort) ||
                       (command != op_log_dma && command != op_write_block);

  ////////////////////////////////////////////////////////////////////////////
  // Command state machine.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (command_write) begin
            if (command == op_log_dma) begin
              state <= log_abort ? st_done : st_dma_data;
            end else if (command == op_write_block) begin
              state <= st_pio_data;
            end else begin
              state <= st_done;
            end
          end
        end
        st_pio_data, st_dma_data: begin
          if (last_word) begin
            state <= st_commit;
          end
        end
        st_commit: begin
          if (media_done) begin
            state <= st_done;
          end
        end
        st_done: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command attributes, captured once as the command byte lands.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      is_dma <= 1'b0;
      lba_mode <= 1'b0;
    end else if (state == st_idle && command_write) begin
      is_dma <= (command == op_log_dma);
      lba_mode <= task_file.head_select[dh_lba_mode];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word counter within the current sector.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_count <= 8'h00;
    end else if (state == st_idle && command_write) begin
      word_count <= 8'h00;
    end else if (word_in) begin
      word_count <= word_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sectors still owed by the host.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= 16'h0000;
    end else if (state == st_idle && command_write) begin
      if (command == op_log_dma) begin
        remaining <= {task_file.count_prev, task_file.count};
      end else if (task_file.count == 8'h00) begin
        remaining <= {7'h00, count_zero_means};
      end else begin
        remaining <= {8'h00, task_file.count};
      end
    end else if (state == st_commit && media_error) begin
      // failed commit
      // The data goes to media in one commit, so a media failure can only name the sector
      // in flight; the count then reports that one sector as not transferred.
      remaining <= 16'h0001;
    end else if (sector_end) begin
      remaining <= remaining - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sectors left in the current interrupt block.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_left <= 8'h00;
    end else if (state == st_idle && command_write) begin
      block_left <= block_size;
    end else if (sector_end) begin
      block_left <= (block_left == 8'h01) ? block_size : block_left - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current location; holds the last transferred sector at completion.
  // The step is skipped on the last sector so no extra increment needs undoing later.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr <= 28'h0000000;
    end else if (state == st_idle && command_write) begin
      addr <= start_addr;
    end else if (sector_end && !last_word) begin
      addr <= next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Words toward media, one cycle behind acceptance.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      media_word <= '0;
    end else begin
      media_word.valid <= word_in;
      media_word.data <= (state == st_dma_data) ? dma_word.data : data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit strobe, raised once behind the last word.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      media_commit <= 1'b0;
    end else begin
      media_commit <= last_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA words are wanted until the last one has been taken.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= (state == st_dma_data) && !last_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: one pulse per completed block of the block write, and one at completion.
  // The last block is covered by the completion pulse, so it gets no pulse of its own.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt <= 1'b0;
    end else begin
      interrupt <= (state == st_pio_data && sector_end && block_left == 8'h01 && !last_word) ||
                   (state == st_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_status <= status_reset;
    end else begin
      // Busy rises on the edge that takes the last word, as the data request falls, so
      // the host never sees a cycle with neither set before completion.
      drive_status[st_busy] <= (state == st_commit) || (state == st_idle && command_write) ||
                               last_word;
      drive_status[st_data_req] <= (state == st_pio_data) && !last_word;
      drive_status[st_ready] <= 1'b1;
      drive_status[st_seek_done] <= 1'b1;
      if (state == st_idle && command_write) begin
        drive_status[st_error] <= cmd_refused;
      end else if (state == st_commit && media_error) begin
        drive_status[st_error] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error register; each new command starts from a clean value.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      error_flags <= error_reset;
    end else if (state == st_idle && command_write) begin
      error_flags <= error_reset;
      if (cmd_refused) begin
        error_flags[er_abort] <= 1'b1;
      end
    end else if (state == st_commit && media_error) begin
      // Only the log write reports an uncorrectable failure; the block write reports
      // the failing sector as not found.
      error_flags[er_uncorrectable] <= is_dma;
      error_flags[er_id_not_found] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion registers for the block write; the log write leaves them alone.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_head_select <= head_select_reset;
      count_out <= 8'h00;
      sector_out <= 8'h00;
      cyl_low_out <= 8'h00;
      cyl_high_out <= 8'h00;
    end else if (state == st_done && !is_dma) begin
      count_out <= drive_status[st_error] ? remaining[7:0] : 8'h00;
      sector_out <= addr[7:0];
      cyl_low_out <= addr[15:8];
      cyl_high_out <= addr[23:16];
      drive_head_select <= {drive_head_select[7:4], addr[27:24]};
    end
  end
endmodule : write_cmd
`default_nettype wire

/* File: hdl/wrmul_pkg.sv */
// Shared constants and carrier types for the task-file write command interpreter.
// Assumes a single 100 MHz clock domain and a host that owns the command block.
//
// What this block does
// - Opcode 57h written to the command register starts a log write whose data moves over DMA.
// - The DMA log write applies the same parameters, checks and aborts as the PIO log write.
// - The log write count is 16 bits from current and previous count bytes; too large aborts.
// - A log write aborts for a read-only log, an unsupported log, or invalid fields.
// - Opcode C5h written to the command register starts the block-interrupt PIO write.
// - The multi-sector write accepts one or more sectors and then commits them to media.
// - The multi-sector write interrupts once per configured block, not once per sector.
// - Sector data arrives one 16-bit word per data register access.
// - The sector count gives the sectors to write, with zero meaning 256.
// - With the address-mode bit clear the start is cylinder, head and sector.
// - With the address-mode bit set the start is a 28-bit block address.
// - At block write completion the count register holds the sectors left untransferred; the log write leaves it unchanged.
// - At block write completion the address registers hold the last sector transferred; the log write leaves them unchanged.
package wrmul_pkg;
  localparam logic [7:0] op_log_dma = 8'h57;
  localparam logic [7:0] op_write_block = 8'hc5;
  localparam int words_per_sector = 256;
  localparam logic [8:0] count_zero_means = 9'h100;
  // Status bit positions.
  localparam int st_busy = 7;
  localparam int st_ready = 6;
  localparam int st_seek_done = 4;
  localparam int st_data_req = 3;
  localparam int st_error = 0;
  // Error bit positions.
  localparam int er_uncorrectable = 6;
  localparam int er_id_not_found = 4;
  localparam int er_abort = 2;
  // Device/head fields.
  localparam int dh_lba_mode = 6;
  localparam logic [7:0] status_reset = 8'h50;
  localparam logic [7:0] error_reset = 8'h00;
  localparam logic [7:0] head_select_reset = 8'ha0;
  localparam logic [15:0] log_limit_default = 16'h0010;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_pio_data = 3'b001,
    st_dma_data = 3'b010,
    st_commit = 3'b011,
    st_done = 3'b100
  } cmd_state_t;

  // Command block as written by the host: current and previous bytes.
  typedef struct packed {
    logic [7:0] count_prev;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_low_prev;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] head_select;
  } task_file_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } data_word_t;
endpackage : wrmul_pkg

/* File: verif/media_model.sv */
// Model of the media and DMA engines beside the interpreter.
// Assumes commits are single-cycle pulses and DMA is wanted while requested.
`timescale 1ns/1ns
`default_nettype none
module media_model
  import wrmul_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic dma_request,
  input wire logic media_commit,
  output logic media_done,
  output data_word_t dma_word
);
  logic busy;
  logic phase;
  logic [3:0] wait_cnt;
  logic [15:0] word_cnt;
  logic dma_valid;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      media_done <= 1'b0;
    end else begin
      media_done <= busy && wait_cnt == 4'h0;
      if (media_commit) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 4'h9 : 4'h0;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else begin
        busy <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 1'b0;
      word_cnt <= 16'h0000;
    end else begin
      phase <= ~phase;
      word_cnt <= media_commit ? 16'h0000 : word_cnt + 16'(dma_valid);
    end
  end
  // Idle data is inverted so a stale word can never pass for a fresh one.
  assign dma_valid = dma_request && (phase || !slow);
  assign dma_word = {dma_valid, dma_valid ? word_cnt : ~word_cnt};
endmodule : media_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the write command interpreter.
// Assumes the media model answers commits and feeds DMA words.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wrmul_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slow = 1'b0;
  task_file_t task_file = '0;
  task_file_t tf;
  logic command_write = 1'b0;
  logic [7:0] command = 8'h00;
  logic data_write = 1'b0;
  logic [15:0] data_in = 16'h0000;
  logic [255:0] log_read_only = 256'h100;
  logic [255:0] log_supported = ~256'h200;
  logic media_error = 1'b0;
  data_word_t dma_word, media_word;
  logic [7:0] error_flags, drive_status, drive_head_select, count_out;
  logic [7:0] sector_out, cyl_low_out, cyl_high_out;
  logic media_done, interrupt, dma_request, media_commit;
  int failures = 0;
  int checks_done = 0;
  int irq_seen = 0;
  logic [15:0] exp_q[$];
  always #5 clk = ~clk;
  write_cmd #(.block_size(8'h02)) dut (.clk(clk), .reset_n(reset_n), .task_file(task_file),
    .command_write(command_write), .command(command), .data_write(data_write),
    .data_in(data_in), .dma_word(dma_word), .log_limit(log_limit_default),
    .log_read_only(log_read_only), .log_supported(log_supported), .media_done(media_done),
    .media_error(media_error), .error_flags(error_flags), .drive_status(drive_status),
    .drive_head_select(drive_head_select), .count_out(count_out), .sector_out(sector_out),
    .cyl_low_out(cyl_low_out), .cyl_high_out(cyl_high_out), .interrupt(interrupt),
    .dma_request(dma_request), .media_word(media_word), .media_commit(media_commit));
  media_model media (.clk(clk), .reset_n(reset_n), .slow(slow), .dma_request(dma_request),
    .media_commit(media_commit), .media_done(media_done), .dma_word(dma_word));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Words arriving with no note pending are compared against their own inverse.
  always @(posedge clk) begin
    if (media_word.valid === 1'b1) begin
      check("media word", exp_q.size() > 0 ? exp_q.pop_front() : ~media_word.data,
        media_word.data);
    end
    if (interrupt === 1'b1) irq_seen++;
  end
  // Data is offered only while a request stands, so no word is ever refused.
  task automatic run_cmd(input logic [7:0] op, input int words);
    int n;
    n = 0;
    irq_seen = 0;
    task_file = tf;
    command = op;
    command_write = 1'b1;
    @(posedge clk);
    #1 command_write = 1'b0;
    while (n < 70000 && (words > 0 || n < 2 || drive_status[st_busy] === 1'b1 ||
        drive_status[st_data_req] === 1'b1 || dma_request === 1'b1)) begin
      data_write = words > 0 && drive_status[st_data_req] === 1'b1;
      data_in = 16'($urandom);
      if (data_write) begin
        exp_q.push_back(data_in);
        words--;
      end
      @(posedge clk);
      #1 n++;
    end
    data_write = 1'b0;
    if (n >= 70000) begin
      failures++;
      finish_test();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : run_cmd
  task automatic check_done(input logic [27:0] last, input int irqs);
    check("count", 16'h0, 16'(count_out));
    check("sector", 16'(last[7:0]), 16'(sector_out));
    check("cyl low", 16'(last[15:8]), 16'(cyl_low_out));
    check("cyl high", 16'(last[23:16]), 16'(cyl_high_out));
    check("head", 16'(last[27:24]), 16'(drive_head_select[3:0]));
    check("interrupts", 16'(irqs), 16'(irq_seen));
  endtask : check_done
  initial begin
    void'($urandom(32'h3bfe));
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    check("status", 16'(status_reset), 16'(drive_status));
    check("error", 16'(error_reset), 16'(error_flags));
    check("head reg", 16'(head_select_reset), 16'(drive_head_select));
    // a data write with no command open must not reach media
    data_write = 1'b1;
    data_in = 16'($urandom);
    @(posedge clk);
    #1 data_write = 1'b0;
    tf = {8'h00, 8'h01, 8'h05, 8'h00, 8'h34, 8'h12, 8'ha3};
    run_cmd(op_write_block, 256);
    check_done(28'h3123405, 1);
    // a failed commit reports one sector left
    media_error = 1'b1;
    run_cmd(op_write_block, 256);
    media_error = 1'b0;
    check("error count", 16'h1, 16'(count_out));
    check("media error", 16'(1 << er_id_not_found), 16'(error_flags));
    check("media status", 16'h1, 16'(drive_status[st_error]));
    slow = 1'b1;
    tf = {8'h00, 8'h03, 8'h56, 8'h00, 8'h34, 8'h12, 8'he1};
    run_cmd(op_write_block, 768);
    check_done(28'h1123458, 2);
    slow = 1'b0;
    tf = {8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'he0};
    run_cmd(op_write_block, 65536);
    check_done(28'h00001fe, 128);
    for (int i = 0; i < 5; i++) begin
      tf = {8'h00, i == 2 ? 8'h11 : 8'h01, i == 0 ? 8'h08 : (i == 1 ? 8'h09 : 8'h01),
        i == 3 ? 8'h01 : 8'h00, 8'h00, 8'h00, 8'ha0};
      run_cmd(i == 4 ? 8'h20 : op_log_dma, 0);
      check("abort", 16'h1, 16'(error_flags[er_abort]));
      check("error bit", 16'h1, 16'(drive_status[st_error]));
    end
    // log write over a stalling DMA path
    slow = 1'b1;
    tf = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'ha0};
    for (int i = 0; i < 256; i++) exp_q.push_back(16'(i));
    run_cmd(op_log_dma, 0);
    check("log error", 16'h0, 16'(error_flags));
    check("words left", 16'h0, 16'(exp_q.size()));
    check("log irq", 16'h1, 16'(irq_seen));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

/* File: verif/write_cmd_sva.sv */
// Assertions on the write command interpreter ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module write_cmd_sva
  import wrmul_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic command_write,
  input wire logic [7:0] command,
  input wire logic data_write,
  input wire logic [15:0] data_in,
  input wire data_word_t dma_word,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] drive_status,
  input wire logic interrupt,
  input wire logic dma_request,
  input wire data_word_t media_word,
  input wire logic media_commit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic drq;
  logic idle;
  assign drq = drive_status[st_data_req];
  assign idle = !drive_status[st_busy] && !drq && !dma_request;
  a_block_opcode: assert property (
    command_write && idle && command == op_write_block |=>
      drive_status[st_busy] ##1 (drq && !drive_status[st_busy]))
    else $error("block write gave no data request");
  a_log_opcode: assert property (
    command_write && idle && command == op_log_dma |-> ##[1:2] (dma_request || error_flags[er_abort]))
    else $error("log write neither started nor aborted");
  a_pio_word: assert property (
    data_write && drq |=> media_word.valid && media_word.data == $past(data_in))
    else $error("data word not passed on");
  a_dma_word: assert property (
    dma_word.valid && dma_request |=> media_word.valid && media_word.data == $past(dma_word.data))
    else $error("dma word not passed on");
  a_word_refused: assert property (
    data_write && !drq && !(dma_word.valid && dma_request) |=> !media_word.valid)
    else $error("word taken outside transfer");
  a_abort_status: assert property (
    $rose(error_flags[er_abort]) |-> drive_status[st_error])
    else $error("abort without error status");
  a_irq_pulse: assert property (interrupt |=> !interrupt)
    else $error("interrupt longer than one cycle");
  a_commit_pulse: assert property (media_commit |=> !media_commit)
    else $error("commit longer than one cycle");
  a_drq_not_busy: assert property (drq |-> !drive_status[st_busy])
    else $error("data request while busy");
endmodule : write_cmd_sva
bind write_cmd write_cmd_sva chk (.clk(clk), .reset_n(reset_n), .command_write(command_write),
  .command(command), .data_write(data_write), .data_in(data_in), .dma_word(dma_word),
  .error_flags(error_flags), .drive_status(drive_status), .interrupt(interrupt),
  .dma_request(dma_request), .media_word(media_word), .media_commit(media_commit));
`default_nettype wire
